/* File: sdac_pkg.sv */
// Constants, types and state layout of the serial converter front end
package sdac_pkg;

    // ------------------------------------------------------------------
    // Code and framing
    // ------------------------------------------------------------------
    localparam int CODE_W = 16;
    localparam int OSR = 16;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] MID_LAST = 4'h7;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [4:0] FERR_LEN = 5'h10;
    localparam logic [15:0] CODE_MIN = 16'h0000;
    localparam int FIFO_DEPTH = 4;

    // ------------------------------------------------------------------
    // Modulator timing and scaling
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int MOD_PERIOD_NS = 1000;
    localparam int MOD_DIV_INT = (MOD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] MOD_DIV_LAST = 6'(MOD_DIV_INT - 1);
    localparam logic signed [23:0] MOD_FB_POS = 24'sh008000;
    localparam logic signed [23:0] MOD_FB_NEG = 24'shFF8000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } sdac_rx_t;

    typedef struct packed {
        logic data;
        logic dclk;
        logic latch;
        logic clear;
        logic headroom;
        logic fault_line;
    } sdac_pins_t;

    typedef struct packed {
        sdac_pins_t s1;
        sdac_pins_t s2;
        logic dclk_prev;
        logic latch_prev;
        logic async_mode;
        logic [15:0] shift;
        logic dout;
        logic [15:0] hold;
        logic pend;
        logic [15:0] code;
        sdac_rx_t rx;
        logic rx_line_prev;
        logic [3:0] os_cnt;
        logic [3:0] bit_cnt;
        logic [15:0] rx_word;
        logic [4:0] ferr_cnt;
        logic [5:0] div_cnt;
        logic signed [23:0] int1;
        logic signed [27:0] int2;
        logic mod_bit;
        logic fault_oe;
        logic loop_fault;
    } sdac_state_t;

    localparam sdac_state_t ST_RST = '{
        s1: '{fault_line: 1'b1, default: '0},
        s2: '{fault_line: 1'b1, default: '0},
        rx: RX_IDLE,
        default: '0
    };

endpackage : sdac_pkg

/* File: sdac_fifo.sv */
// Small word FIFO between the latch and the modulator
`timescale 1ns/1ps
module sdac_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic flush_in,
    // Filling side
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    // Draining side
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } sdac_fifo_st_t;

    sdac_fifo_st_t st_reg;
    sdac_fifo_st_t st_next;
    logic full;
    logic empty;

    // ------------------------------------------------------------------
    // Pointer logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        empty = (st_reg.wr == st_reg.rd);
        full = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
        if (in_valid_in && !full)
        begin
            st_next.mem[st_reg.wr[AW-1:0]] = in_data_in;
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (out_ready_in && !empty)
        begin
            st_next.rd = st_reg.rd + 1'b1;
        end
        if (flush_in)
        begin
            st_next.wr = '0;
            st_next.rd = '0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = st_reg.mem[st_reg.rd[AW-1:0]];

endmodule : sdac_fifo

/* File: sdac_core.sv */
// Serial input, latch, modulator and fault logic of the converter
//
// Behaviour
// - Three-wire: bits gather in input register, reach converter only on latch.
// - Shift register samples data and advances once per data clock rise with latch low.
// - Latch copies shift register into internal latch; converter input follows later via FIFO on a modulator tick.
// - Latch held high permanently selects asynchronous mode.
// - Async mode: start and stop framing triggers the internal latch.
// - Three-wire serial output shows bits shifted out of the register.
// - Shared latch after the full chain updates all devices together.
// - Device only forwards bits, so chain length is unlimited.
// - Fault flag is active-low open drain for wired sharing.
// - Fault asserts three clock edges after headroom indicator reports low drive.
// - Code is 16 bits; all ones near full scale, zeros bottom.
// - Latched code drives second-order single-bit sigma-delta modulator.
// - Clear forces minimum output, holds after release, input register untouched.
// - Three-wire latch transfer happens on rising latch edge.
// - Async data clock is sixteen times bit rate; oversample by sixteen.
// - Async serial output pulses high after a bad frame's stop bit.
`timescale 1ns/1ps
module sdac_core (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Serial pins
    input wire logic data_in,
    input wire logic dclk_in,
    input wire logic latch_in,
    output logic data_out,
    // Clear pin
    input wire logic clear_in,
    // Fault pin and headroom indicator
    input wire logic headroom_low_in,
    input wire logic fault_line_in,
    output logic fault_o_out,
    output logic fault_oe_out,
    output logic loop_fault_out,
    // Converter side
    output logic [15:0] code_out,
    output logic [15:0] latch_word_out,
    output logic mod_bit_out,
    output logic async_mode_out
);
    sdac_pkg::sdac_state_t st_reg;
    sdac_pkg::sdac_state_t st_next;
    logic dclk_rise;
    logic latch_rise;
    logic latch_evt;
    logic mod_tick;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic signed [23:0] mod_x;
    logic signed [23:0] mod_fb;
    logic signed [23:0] int1_n;
    logic signed [27:0] int2_n;

    function automatic logic sdac_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction : sdac_rise

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        latch_evt = 1'b0;
        st_next.s1.data = data_in;
        st_next.s1.dclk = dclk_in;
        st_next.s1.latch = latch_in;
        st_next.s1.clear = clear_in;
        st_next.s1.headroom = headroom_low_in;
        st_next.s1.fault_line = fault_line_in;
        st_next.s2 = st_reg.s1;
        st_next.dclk_prev = st_reg.s2.dclk;
        st_next.latch_prev = st_reg.s2.latch;
        dclk_rise = sdac_rise(st_reg.dclk_prev, st_reg.s2.dclk);
        latch_rise = sdac_rise(st_reg.latch_prev, st_reg.s2.latch);

        if (dclk_rise)
        begin
            st_next.async_mode = st_reg.s2.latch;
            st_next.rx_line_prev = st_reg.s2.data;
            if (!st_reg.s2.latch)
            begin
                st_next.shift = {st_reg.shift[14:0], st_reg.s2.data};
                st_next.rx = sdac_pkg::RX_IDLE;
                st_next.ferr_cnt = '0;
            end
            else
            begin
                if (st_reg.ferr_cnt != '0)
                    st_next.ferr_cnt = st_reg.ferr_cnt - 5'h01;
                unique case (st_reg.rx)
                    sdac_pkg::RX_IDLE:
                    begin
                        if (st_reg.rx_line_prev && !st_reg.s2.data)
                        begin
                            st_next.rx = sdac_pkg::RX_START;
                            st_next.os_cnt = '0;
                        end
                    end
                    sdac_pkg::RX_START:
                    begin
                        st_next.os_cnt = st_reg.os_cnt + 4'h1;
                        if (st_reg.os_cnt == sdac_pkg::MID_LAST)
                        begin
                            st_next.os_cnt = '0;
                            st_next.bit_cnt = '0;
                            st_next.rx = st_reg.s2.data ? sdac_pkg::RX_IDLE : sdac_pkg::RX_DATA;
                        end
                    end
                    sdac_pkg::RX_DATA:
                    begin
                        st_next.os_cnt = st_reg.os_cnt + 4'h1;
                        if (st_reg.os_cnt == sdac_pkg::OS_LAST)
                        begin
                            st_next.rx_word = {st_reg.rx_word[14:0], st_reg.s2.data};
                            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                            if (st_reg.bit_cnt == sdac_pkg::BIT_LAST)
                                st_next.rx = sdac_pkg::RX_STOP;
                        end
                    end
                    sdac_pkg::RX_STOP:
                    begin
                        st_next.os_cnt = st_reg.os_cnt + 4'h1;
                        if (st_reg.os_cnt == sdac_pkg::OS_LAST)
                        begin
                            st_next.rx = sdac_pkg::RX_IDLE;
                            if (st_reg.s2.data)
                            begin
                                st_next.hold = st_reg.rx_word;
                                latch_evt = 1'b1;
                            end
                            else
                            begin
                                st_next.ferr_cnt = sdac_pkg::FERR_LEN;
                            end
                        end
                    end
                    default:
                    begin
                        st_next.rx = sdac_pkg::RX_IDLE;
                    end
                endcase
            end
        end

        if (latch_rise && !st_reg.async_mode)
        begin
            st_next.hold = st_reg.shift;
            latch_evt = 1'b1;
        end

        if (st_reg.pend && fifo_in_ready)
            st_next.pend = 1'b0;
        if (latch_evt)
            st_next.pend = 1'b1;

        // Modulator rate divider
        mod_tick = (st_reg.div_cnt == sdac_pkg::MOD_DIV_LAST);
        st_next.div_cnt = mod_tick ? 6'h00 : st_reg.div_cnt + 6'h01;
        fifo_out_ready = mod_tick && !st_reg.s2.clear;
        if (fifo_out_ready && fifo_out_valid)
            st_next.code = fifo_out_data;

        if (st_reg.s2.clear)
        begin
            st_next.code = sdac_pkg::CODE_MIN;
            st_next.pend = 1'b0;
        end

        mod_x = {{8{~st_reg.code[15]}}, ~st_reg.code[15], st_reg.code[14:0]};
        mod_fb = st_reg.mod_bit ? sdac_pkg::MOD_FB_POS : sdac_pkg::MOD_FB_NEG;
        int1_n = st_reg.int1 + mod_x - mod_fb;
        int2_n = st_reg.int2 + {{4{int1_n[23]}}, int1_n} - {{4{mod_fb[23]}}, mod_fb};
        if (mod_tick)
        begin
            st_next.int1 = int1_n;
            st_next.int2 = int2_n;
            st_next.mod_bit = ~int2_n[27];
        end

        st_next.dout = st_next.async_mode ? (st_next.ferr_cnt != '0) : st_next.shift[15];

        st_next.fault_oe = st_reg.s2.headroom;
        st_next.loop_fault = ~st_reg.s2.fault_line;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
            st_reg <= sdac_pkg::ST_RST;
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Word FIFO
    // ------------------------------------------------------------------
    sdac_fifo #(
        .W(sdac_pkg::CODE_W),
        .DEPTH(sdac_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .flush_in(st_reg.s2.clear),
        .in_valid_in(st_reg.pend),
        .in_data_in(st_reg.hold),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(fifo_out_ready)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign data_out = st_reg.dout;
    assign fault_o_out = 1'b0;
    assign fault_oe_out = st_reg.fault_oe;
    assign loop_fault_out = st_reg.loop_fault;
    assign code_out = st_reg.code;
    assign latch_word_out = st_reg.hold;
    assign mod_bit_out = st_reg.mod_bit;
    assign async_mode_out = st_reg.async_mode;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_wire_rise;
        dclk_rise && !st_reg.s2.latch;
    endsequence

    sequence s_stop_sample;
        dclk_rise && st_reg.s2.latch && st_reg.rx == sdac_pkg::RX_STOP && st_reg.os_cnt == 4'hF;
    endsequence

    sequence s_three_wire_latch;
        latch_rise && !st_reg.async_mode && !st_reg.s2.clear;
    endsequence

    chk_shift_msb_first: assert property (
        s_wire_rise |=> st_reg.shift == {$past(st_reg.shift[14:0]), $past(st_reg.s2.data)})
        else $error("shift register did not advance msb first");

    chk_latch_capture: assert property (
        s_three_wire_latch |=> st_reg.pend && st_reg.hold == $past(st_reg.shift))
        else $error("latch edge did not capture shift register");

    chk_code_only_latched: assert property (
        $changed(st_reg.code) |-> $past(fifo_out_ready && fifo_out_valid) || $past(st_reg.s2.clear))
        else $error("converter code changed without latch or clear");

    chk_chain_out: assert property (
        s_wire_rise ##1 1'b1 |=> data_out == $past(st_reg.shift[15]) && !async_mode_out)
        else $error("serial output not the shifted out bit");

    chk_fault_follow: assert property (
        st_reg.s2.headroom |=> fault_oe_out && !fault_o_out)
        else $error("fault flag not driven low on low headroom");

    chk_clear_min: assert property (
        st_reg.s2.clear ##1 !st_reg.s2.clear |-> code_out == 16'h0000 && $stable(st_reg.shift))
        else $error("clear did not leave code at minimum");

    chk_async_select: assert property (
        dclk_rise && st_reg.s2.latch |=> async_mode_out && $stable(st_reg.shift))
        else $error("high latch did not select asynchronous mode");

    chk_frame_error: assert property (
        s_stop_sample ##0 !st_reg.s2.data |=> data_out [*8])
        else $error("bad stop bit did not pulse serial output");

    chk_frame_latch: assert property (
        s_stop_sample ##0 st_reg.s2.data && !st_reg.s2.clear |=> st_reg.pend && st_reg.hold == $past(st_reg.rx_word))
        else $error("good frame did not set internal latch");

    chk_start_mid: assert property (
        dclk_rise && st_reg.s2.latch && st_reg.rx == sdac_pkg::RX_START && st_reg.os_cnt == 4'h7 && st_reg.s2.data
        |=> st_reg.rx == sdac_pkg::RX_IDLE)
        else $error("false start bit not rejected at mid bit");

    chk_mod_tick_hold: assert property (
        !mod_tick |=> $stable(mod_bit_out) && $stable(st_reg.int2))
        else $error("modulator moved between ticks");

    chk_pend_stall: assert property (
        st_reg.pend && !fifo_in_ready && !st_reg.s2.clear |=> st_reg.pend)
        else $error("pending word lost while fifo full");

    chk_clear_flush: assert property (
        st_reg.s2.clear |=> code_out == 16'h0000 && !st_reg.pend)
        else $error("clear did not force minimum and drop pending word");

    chk_loop_fault_wire: assert property (
        !st_reg.s2.fault_line |=> loop_fault_out)
        else $error("low shared fault line not reported");

    chk_wire_mode: assert property (
        s_wire_rise |=> !async_mode_out)
        else $error("low latch at clock rise did not select three-wire mode");

endmodule : sdac_core

/* File: sdac_host.sv */
// Host serial port model driving the converter pins
`timescale 1ns/1ps
module sdac_host #(
    parameter int HALF = 5
) (
    // Clock and chained output readback
    input wire logic clk_sys_in,
    input wire logic dout_in,
    // Serial pins
    output logic data_out,
    output logic dclk_out,
    output logic latch_out
);
    logic [15:0] captured = 16'h0000;
    initial
    begin
        data_out = 1'b1;
        dclk_out = 1'b0;
        latch_out = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : wait_clk
    task automatic one_rise();
        dclk_out = 1'b1;
        wait_clk(HALF);
        dclk_out = 1'b0;
        wait_clk(HALF);
    endtask : one_rise
    task automatic send_bits(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            data_out = w[i];
            wait_clk(HALF);
            captured = {captured[14:0], dout_in};
            one_rise();
        end
        data_out = ~data_out;
    endtask : send_bits
    task automatic pulse_latch();
        latch_out = 1'b1;
        wait_clk(6);
        latch_out = 1'b0;
        wait_clk(6);
    endtask : pulse_latch
    task automatic idle_rises(input int n);
        data_out = 1'b1;
        repeat (n) one_rise();
    endtask : idle_rises
    // low start, stop bit as given, sixteen clocks a bit
    task automatic send_frame(input logic [15:0] w, input logic stop);
        logic [17:0] f;
        f = {1'b0, w, stop};
        for (int i = 17; i >= 0; i--)
        begin
            data_out = f[i];
            repeat (16) one_rise();
        end
    endtask : send_frame
endmodule : sdac_host

/* File: tb_top.sv */
// Self-checking testbench of the converter front end
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic clear_in = 1'b0;
    logic headroom_low_in = 1'b0;
    logic other_pull = 1'b0;
    logic data_in, dclk_in, latch_in, data_out, fault_line_in;
    logic fault_o_out, fault_oe_out, loop_fault_out, mod_bit_out, async_mode_out;
    logic [15:0] code_out, latch_word_out;
    int mismatches = 0;
    int n_compared = 0;
    // ------------------------------------------------------------------
    // Clock, reset, wired fault line
    // ------------------------------------------------------------------
    always #10 clk_sys_in = ~clk_sys_in;
    assign fault_line_in = ~(fault_oe_out | other_pull);
    sdac_host u_host (.clk_sys_in(clk_sys_in), .dout_in(data_out), .data_out(data_in),
        .dclk_out(dclk_in), .latch_out(latch_in));
    sdac_core uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .data_in(data_in), .dclk_in(dclk_in),
        .latch_in(latch_in), .data_out(data_out), .clear_in(clear_in), .headroom_low_in(headroom_low_in),
        .fault_line_in(fault_line_in), .fault_o_out(fault_o_out), .fault_oe_out(fault_oe_out),
        .loop_fault_out(loop_fault_out), .code_out(code_out), .latch_word_out(latch_word_out),
        .mod_bit_out(mod_bit_out), .async_mode_out(async_mode_out));
    // ------------------------------------------------------------------
    // Compare and helper tasks
    // ------------------------------------------------------------------
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp16
    task automatic cmp1(input logic got, input logic exp, input string what);
        cmp16({15'h0000, got}, {15'h0000, exp}, what);
    endtask : cmp1
    task automatic clks(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : clks
    task automatic wait_code(input logic [15:0] exp, input int n);
        for (int i = 0; i < n && code_out !== exp; i++) clks(1);
        cmp16(code_out, exp, "code");
    endtask : wait_code
    task automatic count_ones(output int ones);
        clks(1000);
        ones = 0;
        repeat (64)
        begin
            if (mod_bit_out === 1'b1) ones++;
            clks(50);
        end
    endtask : count_ones
    task automatic test_done();
        $display("Counts: mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        cmp16(code_out, sdac_pkg::CODE_MIN, "reset code");
        cmp16(latch_word_out, 16'h0000, "reset latch");
        cmp1(async_mode_out, 1'b0, "reset mode");
    endtask : t_reset
    task automatic t_three_wire();
        u_host.send_bits(32'h0000C35A, 16);
        clks(10);
        cmp16(code_out, 16'h0000, "code before latch");
        u_host.pulse_latch();
        cmp16(latch_word_out, 16'hC35A, "latched word");
        wait_code(16'hC35A, 60);
    endtask : t_three_wire
    task automatic t_chain();
        int ones;
        u_host.send_bits(32'h1234FFFF, 32);
        cmp16(u_host.captured, 16'h1234, "chained output");
        u_host.pulse_latch();
        cmp16(latch_word_out, 16'hFFFF, "near word");
        wait_code(16'hFFFF, 60);
        count_ones(ones);
        cmp1(ones >= 60, 1'b1, "full scale stream");
    endtask : t_chain
    task automatic t_clear();
        int ones;
        clear_in = 1'b1;
        wait_code(sdac_pkg::CODE_MIN, 60);
        cmp16(latch_word_out, 16'hFFFF, "latch under clear");
        clear_in = 1'b0;
        clks(200);
        cmp16(code_out, sdac_pkg::CODE_MIN, "code after clear");
        count_ones(ones);
        cmp1(ones == 0, 1'b1, "zero code stream");
        u_host.pulse_latch();
        cmp16(latch_word_out, 16'hFFFF, "input register kept");
        wait_code(16'hFFFF, 60);
    endtask : t_clear
    task automatic t_queue();
        logic [15:0] seen[$];
        logic [15:0] prev;
        prev = code_out;
        fork
            begin
                u_host.send_bits(32'h0, 1);
                u_host.pulse_latch();
                u_host.send_bits(32'h1, 1);
                u_host.pulse_latch();
                u_host.send_bits(32'h0, 1);
                u_host.pulse_latch();
            end
            repeat (400)
            begin
                clks(1);
                if (code_out !== prev) seen.push_back(code_out);
                prev = code_out;
            end
        join
        cmp16(16'(seen.size()), 16'h0003, "queued words");
        while (seen.size() < 3) seen.push_back(16'h0000);
        cmp16(seen[0], 16'hFFFE, "first queued");
        cmp16(seen[1], 16'hFFFD, "second queued");
        cmp16(seen[2], 16'hFFFA, "third queued");
    endtask : t_queue
    task automatic t_fault();
        headroom_low_in = 1'b1;
        clks(6);
        cmp1(fault_oe_out, 1'b1, "fault driven");
        cmp1(fault_o_out, 1'b0, "fault pulls low");
        cmp1(loop_fault_out, 1'b1, "fault seen");
        headroom_low_in = 1'b0;
        other_pull = 1'b1;
        clks(6);
        cmp1(fault_oe_out, 1'b0, "fault released");
        cmp1(loop_fault_out, 1'b1, "shared fault");
        other_pull = 1'b0;
        clks(6);
        cmp1(loop_fault_out, 1'b0, "line idle");
    endtask : t_fault
    task automatic t_async();
        u_host.latch_out = 1'b1;
        u_host.idle_rises(4);
        cmp1(async_mode_out, 1'b1, "async mode");
        u_host.send_frame(16'h3CA5, 1'b1);
        u_host.idle_rises(2);
        cmp16(latch_word_out, 16'h3CA5, "framed word");
        wait_code(16'h3CA5, 60);
        u_host.data_out = 1'b0;
        repeat (4) u_host.one_rise();
        u_host.idle_rises(290);
        cmp16(latch_word_out, 16'h3CA5, "false start ignored");
        u_host.send_frame(16'h0F0F, 1'b0);
        clks(6);
        cmp1(data_out, 1'b1, "framing error pulse");
        cmp16(latch_word_out, 16'h3CA5, "bad frame dropped");
        u_host.idle_rises(20);
        cmp1(data_out, 1'b0, "pulse ended");
    endtask : t_async
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rstn_in = 1'b1;
        clks(4);
        t_reset();
        t_three_wire();
        t_chain();
        t_clear();
        t_queue();
        t_fault();
        t_async();
        test_done();
    end
    initial
    begin
        repeat (60000) @(posedge clk_sys_in);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end
endmodule : tb_top
